// file: hw/sqv_regs.sv
/*
 * sqv_regs: queue management control word, vlan entry staging word zero,
 * table access start/action, queue split and forwarding source selection.
 * assumes: software register port is synchronous to clk, one access per cycle;
 * the vlan table itself lives outside and takes commit_write and commit_word.
 */
`timescale 1ns/1ns
// Functional notes
// - two-bit split code chooses which regenerated priorities go high; reset code 10
// - discard bit at one restricts all frames to port membership map
// - discard bit zero leaves single-destination frames unrestricted
// - discard zero with mirroring drops mirrored single-destination frames
// - bit 31 of entry word marks entry valid, resets to zero
// - forward bit 27 selects entry port map, else lookup result
// - entry priority in bits 26 to 24, reset zero
// - spanning tree instance in bits 14 to 12, reset zero
// - filter identifier in bits 6 to 0 feeds lookup hash
// - start bit plus write action commits entry; hardware clears start when done
module sqv_regs #(
    parameter int NPORT = sqv_pkg::PORTS
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    input  wire logic [15:0]      reg_addr,
    input  wire logic [31:0]      reg_wdata,
    output logic [31:0]           reg_rdata,
    output logic                  reg_rvalid,
    input  wire logic [1:0]       regen_prio,
    output logic                  queue_high,
    input  wire logic [NPORT-1:0] entry_port_map,
    input  wire logic [NPORT-1:0] lookup_port_map,
    output logic [NPORT-1:0]      fwd_ports,
    input  wire logic             frame_valid,
    input  wire logic [NPORT-1:0] frame_dest_map,
    input  wire logic [NPORT-1:0] frame_member_map,
    input  wire logic             frame_mirrored,
    input  wire logic             mirror_enable,
    output logic                  frame_out_valid,
    output logic [NPORT-1:0]      frame_out_map,
    output logic                  frame_out_drop,
    output logic                  commit_write,
    output logic [31:0]           commit_word,
    output logic                  entry_valid,
    output logic [2:0]            entry_priority,
    output logic [2:0]            spanning_tree_instance,
    output logic [6:0]            filter_identifier
);
    import sqv_pkg::*;

    typedef enum logic [1:0] {
        SQV_IDLE,
        SQV_BUSY
    } sqv_state_t;

    ////////////////////////////////////////////////////////////////////////////
    // register state

    logic [31:0] qmc_r;
    logic [31:0] qmc_nxt;
    logic [31:0] vew_r;
    logic [31:0] vew_nxt;
    logic [1:0]  act_r;
    logic [1:0]  act_nxt;
    logic        start_r;
    logic        start_nxt;
    sqv_state_t  st_r;
    sqv_state_t  st_nxt;
    logic [1:0]  cnt_r;
    logic [1:0]  cnt_nxt;
    logic        cwr_nxt;
    logic [31:0] rdata_nxt;
    logic        hit_qmc;
    logic        hit_vew;
    logic        hit_vtac;
    logic        done;

    assign hit_qmc  = (reg_addr == QMC_OFFSET);
    assign hit_vew  = (reg_addr == VEW0_OFFSET);
    assign hit_vtac = (reg_addr == VTAC_OFFSET);
    assign done     = (st_r == SQV_BUSY) && (cnt_r == 2'(COMMIT_CYCLES - 1));

    // software writes, masked so read-only reserved bits stay zero
    always_comb begin
        qmc_nxt = qmc_r;
        vew_nxt = vew_r;
        act_nxt = act_r;
        if (reg_wr && hit_qmc) begin
            qmc_nxt = reg_wdata & QMC_WMASK;
        end
        if (reg_wr && hit_vew) begin
            vew_nxt = reg_wdata & VEW_WMASK;
        end
        if (reg_wr && hit_vtac && st_r == SQV_IDLE) begin
            act_nxt = reg_wdata[VTAC_ACT_LSB +: 2];
        end
    end

    // start bit and commit sequencing; an access control write while busy is ignored
    always_comb begin
        st_nxt    = st_r;
        cnt_nxt   = cnt_r;
        start_nxt = start_r;
        cwr_nxt   = 1'b0;
        case (st_r)
            SQV_IDLE: begin
                if (reg_wr && hit_vtac && reg_wdata[VTAC_START_BIT]) begin
                    start_nxt = 1'b1;
                    st_nxt    = SQV_BUSY;
                    cnt_nxt   = 2'h0;
                end
            end
            SQV_BUSY: begin
                cnt_nxt = cnt_r + 2'h1;
                if (done) begin
                    start_nxt = 1'b0;
                    cwr_nxt   = (act_r == VTAC_ACT_WRITE);
                    st_nxt    = SQV_IDLE;
                end
            end
            default: begin
                st_nxt    = SQV_IDLE;
                start_nxt = 1'b0;
            end
        endcase
    end

    // read mux, unmapped addresses read zero
    always_comb begin
        rdata_nxt = 32'h00000000;
        if (hit_qmc) begin
            rdata_nxt = qmc_r;
        end else if (hit_vew) begin
            rdata_nxt = vew_r;
        end else if (hit_vtac) begin
            rdata_nxt[VTAC_START_BIT]      = start_r;
            rdata_nxt[VTAC_ACT_LSB +: 2]   = act_r;
        end
    end

    // registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            qmc_r      <= {24'h000000, QMC_SPLIT_RST, 4'h0, QMC_MEMB_RST, 1'h0};
            vew_r      <= VEW_RST;
            act_r      <= VTAC_ACT_NOP;
            start_r    <= 1'b0;
            st_r       <= SQV_IDLE;
            cnt_r      <= 2'h0;
            reg_rdata  <= 32'h00000000;
            reg_rvalid <= 1'b0;
        end else begin
            qmc_r      <= qmc_nxt;
            vew_r      <= vew_nxt;
            act_r      <= act_nxt;
            start_r    <= start_nxt;
            st_r       <= st_nxt;
            cnt_r      <= cnt_nxt;
            reg_rdata  <= reg_rd ? rdata_nxt : 32'h00000000;
            reg_rvalid <= reg_rd;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // queue split and forwarding source

    logic                 high_nxt;
    logic [NPORT-1:0]     fwd_nxt;
    logic [1:0]           split;

    assign split = qmc_r[QMC_SPLIT_LSB +: 2];

    // split priorities between low and high queue
    always_comb begin
        case (split)
            SPLIT_P3:   high_nxt = (regen_prio == 2'h3);
            SPLIT_P23:  high_nxt = (regen_prio >= 2'h2);
            SPLIT_P123: high_nxt = (regen_prio != 2'h0);
            default:    high_nxt = (regen_prio >= 2'h2);
        endcase
        fwd_nxt = vew_r[VEW_FWD_BIT] ? entry_port_map : lookup_port_map;
    end

    // registered decision and entry field outputs
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            queue_high             <= 1'b0;
            fwd_ports              <= '0;
            commit_write           <= 1'b0;
            commit_word            <= 32'h00000000;
            entry_valid            <= 1'b0;
            entry_priority         <= 3'h0;
            spanning_tree_instance <= 3'h0;
            filter_identifier      <= 7'h00;
        end else begin
            queue_high             <= high_nxt;
            fwd_ports              <= fwd_nxt;
            commit_write           <= cwr_nxt;
            commit_word            <= vew_r;
            entry_valid            <= vew_r[VEW_VALID_BIT];
            entry_priority         <= vew_r[VEW_PRIO_LSB +: 3];
            spanning_tree_instance <= vew_r[VEW_MST_LSB +: 3];
            filter_identifier      <= vew_r[VEW_FILTER_LSB +: 7];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // membership filter

    sqv_fwd_filter #(
        .NPORT(NPORT)
    ) i_sqv_fwd_filter (
        .clk           (clk),
        .rst_n         (rst_n),
        .req_valid     (frame_valid),
        .dest_map      (frame_dest_map),
        .member_map    (frame_member_map),
        .mirrored      (frame_mirrored),
        .mirror_enable (mirror_enable),
        .memb_discard  (qmc_r[QMC_MEMB_BIT]),
        .out_valid     (frame_out_valid),
        .out_map       (frame_out_map),
        .out_drop      (frame_out_drop)
    );

    ////////////////////////////////////////////////////////////////////////////
    // checks

    sequence s_start;
        reg_wr && hit_vtac && reg_wdata[VTAC_START_BIT] && st_r == SQV_IDLE;
    endsequence

    sequence s_finish;
        ##[1:3] (!start_r);
    endsequence

    property p_start_clears;
        @(posedge clk) disable iff (!rst_n) s_start |=> start_r ##0 s_finish;
    endproperty
    a_start_clears: assert property (p_start_clears) else $error("start not cleared");

    property p_commit;
        @(posedge clk) disable iff (!rst_n)
        $fell(start_r) && act_r == VTAC_ACT_WRITE |-> commit_write;
    endproperty
    a_commit: assert property (p_commit) else $error("write action not committed");

    property p_split3;
        @(posedge clk) disable iff (!rst_n)
        (split == SPLIT_P3) |=> (queue_high == ($past(regen_prio) == 2'h3));
    endproperty
    a_split3: assert property (p_split3) else $error("split code 00 wrong");

    property p_split123;
        @(posedge clk) disable iff (!rst_n)
        (split == SPLIT_P123) |=> (queue_high == ($past(regen_prio) != 2'h0));
    endproperty
    a_split123: assert property (p_split123) else $error("split code 11 wrong");

    property p_fwd_src;
        @(posedge clk) disable iff (!rst_n)
        vew_r[VEW_FWD_BIT] |=> (fwd_ports == $past(entry_port_map));
    endproperty
    a_fwd_src: assert property (p_fwd_src) else $error("entry port map not used");

    property p_reserved;
        @(posedge clk) disable iff (!rst_n)
        (reg_rd && hit_vew) |=> ((reg_rdata & ~VEW_WMASK) == 32'h00000000);
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved entry bit set");

    property p_fields;
        @(posedge clk) disable iff (!rst_n)
        (reg_wr && hit_vew) ##2 1 |-> (filter_identifier == $past(reg_wdata[6:0], 2)
            && entry_valid == $past(reg_wdata[31], 2));
    endproperty
    a_fields: assert property (p_fields) else $error("entry fields not updated");

    property p_prio_mst;
        @(posedge clk) disable iff (!rst_n)
        (reg_wr && hit_vew) ##2 1 |-> (entry_priority == $past(reg_wdata[26:24], 2)
            && spanning_tree_instance == $past(reg_wdata[14:12], 2));
    endproperty
    a_prio_mst: assert property (p_prio_mst) else $error("priority or instance wrong");

    property p_split23;
        @(posedge clk) disable iff (!rst_n)
        (split == SPLIT_P23) |=> (queue_high == ($past(regen_prio) >= 2'h2));
    endproperty
    a_split23: assert property (p_split23) else $error("split code 10 wrong");

    property p_busy_ignored;
        @(posedge clk) disable iff (!rst_n)
        (reg_wr && hit_vtac && st_r == SQV_BUSY) |=> $stable(act_r);
    endproperty
    a_busy_ignored: assert property (p_busy_ignored) else $error("action changed while busy");

    property p_qmc_reserved;
        @(posedge clk) disable iff (!rst_n)
        (reg_rd && hit_qmc) |=> ((reg_rdata & ~QMC_WMASK) == 32'h00000000);
    endproperty
    a_qmc_reserved: assert property (p_qmc_reserved) else $error("reserved control bit set");
endmodule

// file: shared/sqv_pkg.sv
/*
 * sqv_pkg: shared constants for the queue management control word and the
 * first vlan entry staging word of the switch configuration space.
 * assumes: a simple synchronous register port with byte addresses, 32-bit data.
 */
package sqv_pkg;
    // register byte offsets
    localparam logic [15:0] QMC_OFFSET       = 16'h0390;
    localparam logic [15:0] VEW0_OFFSET      = 16'h0400;
    localparam logic [15:0] VTAC_OFFSET      = 16'h040C;
    // queue management control fields
    localparam int          QMC_SPLIT_LSB    = 6;
    localparam int          QMC_MEMB_BIT     = 1;
    localparam logic [1:0]  QMC_SPLIT_RST    = 2'h2;
    localparam logic        QMC_MEMB_RST     = 1'h1;
    // vlan entry word zero fields
    localparam int          VEW_VALID_BIT    = 31;
    localparam int          VEW_FWD_BIT      = 27;
    localparam int          VEW_PRIO_LSB     = 24;
    localparam int          VEW_MST_LSB      = 12;
    localparam int          VEW_FILTER_LSB   = 0;
    localparam logic [31:0] VEW_WMASK        = 32'h8F00707F;
    localparam logic [31:0] QMC_WMASK        = 32'h000000FF;
    localparam logic [31:0] VEW_RST          = 32'h00000000;
    // access control fields (byte 0x040E sits in word 0x040C, bits 23:16)
    localparam int          VTAC_START_BIT   = 23;
    localparam int          VTAC_ACT_LSB     = 16;
    localparam logic [1:0]  VTAC_ACT_WRITE   = 2'h1;
    localparam logic [1:0]  VTAC_ACT_NOP     = 2'h0;
    // split codes
    localparam logic [1:0]  SPLIT_P3         = 2'h0;
    localparam logic [1:0]  SPLIT_P23        = 2'h2;
    localparam logic [1:0]  SPLIT_P123       = 2'h3;
    localparam int          PORTS            = 5;
    // table commit takes this many cycles
    localparam int          COMMIT_CYCLES    = 2;
endpackage

// file: hw/sqv_fwd_filter.sv
/*
 * sqv_fwd_filter: registered forwarding decision from the frame descriptor and the discard bit.
 * assumes: frame descriptors arrive on the core clock from same-domain logic.
 */
`timescale 1ns/1ns
module sqv_fwd_filter #(
    parameter int NPORT = sqv_pkg::PORTS
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             req_valid,
    input  wire logic [NPORT-1:0] dest_map,
    input  wire logic [NPORT-1:0] member_map,
    input  wire logic             mirrored,
    input  wire logic             mirror_enable,
    input  wire logic             memb_discard,
    output logic                  out_valid,
    output logic [NPORT-1:0]      out_map,
    output logic                  out_drop
);
    import sqv_pkg::*;

    logic             single;
    logic [NPORT-1:0] map_nxt;
    logic             drop_nxt;

    // exactly one destination bit set
    assign single = (dest_map != '0) && ((dest_map & (dest_map - 1'b1)) == '0);

    // membership restriction and mirror drop
    always_comb begin
        map_nxt  = dest_map & member_map;
        drop_nxt = 1'b0;
        if (!memb_discard && single) begin
            map_nxt  = dest_map;
            drop_nxt = mirror_enable && mirrored;
        end
        if (drop_nxt) begin
            map_nxt = '0;
        end
    end

    // register the decision
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            out_valid <= 1'b0;
            out_map   <= '0;
            out_drop  <= 1'b0;
        end else begin
            out_valid <= req_valid;
            out_map   <= map_nxt;
            out_drop  <= req_valid && drop_nxt;
        end
    end

    property p_single_drop;
        @(posedge clk) disable iff (!rst_n)
        (req_valid && !memb_discard && single && mirror_enable && mirrored)
            |=> (out_drop && out_map == '0);
    endproperty
    a_single_drop: assert property (p_single_drop) else $error("single not dropped");

    property p_restrict;
        @(posedge clk) disable iff (!rst_n)
        (req_valid && (memb_discard || !single)) |=> ((out_map & ~$past(member_map)) == '0);
    endproperty
    a_restrict: assert property (p_restrict) else $error("frame left membership map");

    property p_unlimited;
        @(posedge clk) disable iff (!rst_n)
        (req_valid && !memb_discard && single && !(mirror_enable && mirrored))
            |=> (out_map == $past(dest_map));
    endproperty
    a_unlimited: assert property (p_unlimited) else $error("single frame limited");
endmodule

// file: tb/tb.sv
/*
 * tb: self-checking bench for sqv_regs, register port, queue split,
 * forwarding source choice, frame membership filter and table commit.
 * assumes: sqv_pkg compiled first; assertions live in the design files.
 */
`timescale 1ns/1ns
module tb;
    import sqv_pkg::*;
    logic        clk, rst_n, reg_wr, reg_rd, reg_rvalid, queue_high;
    logic [15:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, commit_word;
    logic [1:0]  regen_prio;
    logic [4:0]  entry_port_map, lookup_port_map, fwd_ports;
    logic        frame_valid, frame_mirrored, mirror_enable;
    logic [4:0]  frame_dest_map, frame_member_map, frame_out_map;
    logic        frame_out_valid, frame_out_drop, commit_write, entry_valid;
    logic [2:0]  entry_priority, spanning_tree_instance;
    logic [6:0]  filter_identifier;
    logic [31:0] rq[$];
    logic [5:0]  fq[$];
    logic [31:0] e;
    logic [4:0]  d;
    logic [5:0]  frame_seen;
    int          miscompares, checks_done, cycles, n, seed;
    sqv_regs i_sqv_regs (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .regen_prio(regen_prio), .queue_high(queue_high),
        .entry_port_map(entry_port_map), .lookup_port_map(lookup_port_map),
        .fwd_ports(fwd_ports), .frame_valid(frame_valid), .frame_dest_map(frame_dest_map),
        .frame_member_map(frame_member_map), .frame_mirrored(frame_mirrored),
        .mirror_enable(mirror_enable), .frame_out_valid(frame_out_valid),
        .frame_out_map(frame_out_map), .frame_out_drop(frame_out_drop),
        .commit_write(commit_write), .commit_word(commit_word), .entry_valid(entry_valid),
        .entry_priority(entry_priority), .spanning_tree_instance(spanning_tree_instance),
        .filter_identifier(filter_identifier));
    ////////////////////////////////////////////////////////////////////////////////
    // clock and cycle ceiling
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            report_and_stop();
        end
    end
    // compare one value
    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // register port tasks, one strobe cycle each
    task automatic wr(logic [15:0] a, logic [31:0] v);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(logic [15:0] a, logic [31:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        rq.push_back(exp);
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask
    task automatic idle(int k);
        repeat (k) @(posedge clk);
        @(negedge clk);
    endtask
    // expected frame decision, {drop, map}
    function automatic logic [5:0] frame_exp(logic memb, logic [4:0] ds, logic [4:0] mb,
                                             logic mir, logic men);
        logic single;
        single = $onehot(ds);
        if (!memb && single && mir && men) return 6'h20;
        if (memb || !single) return {1'b0, ds & mb};
        return {1'b0, ds};
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    // result watchers pop the oldest note; a result with no note is a mismatch
    assign frame_seen = {frame_out_drop, frame_out_map};
    always @(negedge clk) begin
        if (reg_rvalid === 1'b1) begin
            check("read_note", rq.size() > 0, 1'b1);
            if (rq.size() > 0)
                check("reg_rdata", reg_rdata, rq.pop_front());
        end
        if (frame_out_valid === 1'b1) begin
            check("frame_note", fq.size() > 0, 1'b1);
            if (fq.size() > 0)
                check("frame_out", frame_seen, fq.pop_front());
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        {reg_wr, reg_rd, reg_addr, reg_wdata, regen_prio} = '0;
        {entry_port_map, lookup_port_map, frame_valid, frame_dest_map} = '0;
        {frame_member_map, frame_mirrored, mirror_enable} = '0;
        seed = 32'hd2f4602b;
        rst_n = 1'b0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        // reset values, unmapped place, reserved bits
        rd(QMC_OFFSET, 32'h00000082);
        rd(VEW0_OFFSET, 32'h00000000);
        wr(QMC_OFFSET, 32'hFFFFFFFF);
        rd(QMC_OFFSET, 32'h000000FF);
        wr(16'h0394, 32'hFFFFFFFF);
        rd(16'h0394, 32'h00000000);
        $display("test reset_and_masks done");
        // split codes against every regenerated priority
        for (int c = 0; c < 4; c++) begin
            wr(QMC_OFFSET, 32'h00000002 | (c << 6));
            for (int p = 0; p < 4; p++) begin
                @(posedge clk);
                regen_prio <= p[1:0];
                idle(1);
                e = (c == 0) ? p == 3 : (c == 3) ? p >= 1 : p >= 2;
                check("queue_high", queue_high, e);
            end
        end
        $display("test queue_split done");
        // entry word fields and forwarding source
        for (int k = 0; k < 6; k++) begin
            e = $random(seed);
            e[27] = k[0];
            wr(VEW0_OFFSET, e);
            e = e & VEW_WMASK;
            rd(VEW0_OFFSET, e);
            entry_port_map <= 5'($random(seed));
            lookup_port_map <= 5'($random(seed));
            idle(2);
            check("entry_valid", entry_valid, e[31]);
            check("entry_priority", entry_priority, e[26:24]);
            check("spanning_tree_instance", spanning_tree_instance, e[14:12]);
            check("filter_identifier", filter_identifier, e[6:0]);
            check("fwd_ports", fwd_ports, e[27] ? entry_port_map : lookup_port_map);
        end
        $display("test entry_fields done");
        // back-to-back frames under both discard settings
        for (int m = 0; m < 2; m++) begin
            wr(QMC_OFFSET, 32'h00000080 | (m << 1));
            for (int k = 0; k < 30; k++) begin
                e = $random(seed);
                d = e[0] ? (5'h01 << (e[7:4] % 5)) : e[12:8];
                @(posedge clk);
                frame_valid <= 1'b1;
                frame_dest_map <= d;
                frame_member_map <= e[20:16];
                frame_mirrored <= e[1];
                mirror_enable <= e[2];
                fq.push_back(frame_exp(m[0], d, e[20:16], e[1], e[2]));
            end
            @(posedge clk);
            frame_valid <= 1'b0;
            idle(3);
        end
        $display("test frame_filter done");
        // mid-run reset brings both words back to their defaults
        wr(QMC_OFFSET, 32'h00000000);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd(QMC_OFFSET, 32'h00000082);
        rd(VEW0_OFFSET, 32'h00000000);
        $display("test midrun_reset done");
        // staged entry commit, start reads back while busy and clears by itself
        e = 32'h8A00507F & VEW_WMASK;
        wr(VEW0_OFFSET, e);
        wr(VTAC_OFFSET, 32'h00810000);
        rd(VTAC_OFFSET, 32'h00810000);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (commit_write !== 1'b1 && n < 20);
        check("commit_write", commit_write, 1'b1);
        check("commit_word", commit_word, e);
        @(negedge clk);
        check("commit_pulse", commit_write, 1'b0);
        rd(VTAC_OFFSET, 32'h00010000);
        // no-op action commits nothing; a start write while busy is ignored
        wr(VTAC_OFFSET, 32'h00800000);
        wr(VTAC_OFFSET, 32'h00810000);
        n = 0;
        repeat (4) begin
            @(negedge clk);
            n += (commit_write === 1'b1);
        end
        check("nop_commit", n, 0);
        rd(VTAC_OFFSET, 32'h00000000);
        $display("test table_commit done");
        idle(4);
        check("pending_notes", rq.size() + fq.size(), 0);
        report_and_stop();
    end
endmodule
